/* File: fsps_defines.svh */
`ifndef FSPS_DEFINES_SVH
`define FSPS_DEFINES_SVH

// ****************************************************
// Register offsets
// ****************************************************
`define FSPS_CTRL_OFS       32'h0000_0000
`define FSPS_STATUS_OFS     32'h0000_0004

// ****************************************************
// Control field positions and reset value
// ****************************************************
`define FSPS_ENABLE_BIT     0
`define FSPS_ERASE_BIT      1
`define FSPS_WRITE_BIT      2
`define FSPS_LOCKSET_BIT    3
`define FSPS_RSECT_BIT      4
`define FSPS_CTRL_RESET     5'h00

// ****************************************************
// Command combinations in the low five control bits
// ****************************************************
`define FSPS_CMD_LOAD       5'h01
`define FSPS_CMD_ERASE      5'h03
`define FSPS_CMD_WRITE      5'h05
`define FSPS_CMD_LOCKSET    5'h09
`define FSPS_CMD_RSECT      5'h11

// ****************************************************
// Status field positions and timing
// ****************************************************
`define FSPS_STAT_BUSY_BIT  0
`define FSPS_STAT_FILL_BIT  1
`define FSPS_ARM_CYCLES     3'h4
`define FSPS_ERASED_WORD    16'hffff

`endif

/* File: fsps_pkg.sv */
package fsps_pkg;

   // ****************************************************
   // Sequencer states, Gray along idle-stream-busy-finish
   // ****************************************************
   typedef enum logic [1:0] {
      FSPS_IDLE   = 2'h0,
      FSPS_STREAM = 2'h1,
      FSPS_BUSY   = 2'h3,
      FSPS_FINISH = 2'h2
   } fsps_fsm_type;

   // ****************************************************
   // Carriers
   // ****************************************************
   typedef struct packed {
      logic        hsel;
      logic [31:0] haddr;
      logic [1:0]  htrans;
      logic        hwrite;
      logic [2:0]  hsize;
      logic [31:0] hwdata;
      logic        hready;
   } fsps_ahb_in_type;

   typedef struct packed {
      logic        valid;
      logic [15:0] z;
      logic [15:0] data;
   } fsps_spm_req_type;

endpackage

/* File: fsps_sequencer.sv */
`timescale 1ns/100ps
`include "fsps_defines.svh"
// Notes on behaviour
// - Armed code 00000011 plus store-program within four cycles erases the Z page.
// - CPU stays stalled for the whole page erase.
// - Armed code 00000001 plus store-program stores R0 at the Z word slot.
// - Buffer clears after a page write and when read-section-enable is written.
// - Buffer is empty after every system reset.
// - An EEPROM write during loading discards all loaded buffer words.
// - Armed code 00000101 plus store-program programs the buffer into the Z page.
// - CPU stays stalled for the whole page write.
// - Buffer slots may be loaded in any order.
// - Store-program is accepted from any flash location; no read-while-write.
// - Enable auto-clears after the instruction or four idle cycles; held during operations.
// - Undefined low five bit patterns written to control have no effect.
// - Writing read-section-enable while filling clears the buffer.
module fsps_sequencer #(
   parameter int PAGE_WORDS = 32
) (
   input  wire logic                               mclk,
   input  wire logic                               reset_n,
   input  wire fsps_pkg::fsps_ahb_in_type          ahbIn,
   output logic                                    hreadyout,
   output logic                                    hresp,
   output logic [31:0]                             hrdata,
   input  wire fsps_pkg::fsps_spm_req_type         spmReq,
   input  wire logic                               eepromWrite,
   input  wire logic                               eepromBusy,
   output logic                                    cpuStall,
   output logic                                    flashErase,
   output logic                                    flashProgram,
   output logic [14-$clog2(PAGE_WORDS):0]          flashPage,
   output logic                                    flashWrEn,
   output logic [$clog2(PAGE_WORDS)-1:0]           flashWordAddr,
   output logic [15:0]                             flashWordData,
   input  wire logic                               flashDone
);
   import fsps_pkg::*;

   localparam int WB = $clog2(PAGE_WORDS);
   localparam int PB = 16 - WB - 1;

   // ****************************************************
   // State
   // ****************************************************
   typedef struct packed {
      fsps_fsm_type                  fsm;
      logic [4:0]                    ctrl;
      logic [2:0]                    armCnt;
      logic [PB-1:0]                 page;
      logic [WB-1:0]                 wordIdx;
      logic [PAGE_WORDS-1:0][15:0]   bufData;
      logic [PAGE_WORDS-1:0]         bufValid;
      logic                          dpValid;
      logic                          dpWrite;
      logic [31:0]                   dpAddr;
      logic [31:0]                   hrdata;
      logic                          flashErase;
      logic                          flashProgram;
      logic                          flashWrEn;
      logic [WB-1:0]                 flashWordAddr;
      logic [15:0]                   flashWordData;
   } fsps_state_type;

   fsps_state_type s_r;
   fsps_state_type s_nxt;

   logic           addrPhase;
   logic           ctrlWrite;
   logic [4:0]     newCmd;
   logic           spmAccept;
   logic [WB-1:0]  spmWord;
   logic [PB-1:0]  spmPage;
   logic           longOp;

   // ****************************************************
   // Helpers
   // ****************************************************
   function automatic logic isValidCmd(input logic [4:0] c);
      return (c == `FSPS_CMD_LOAD) || (c == `FSPS_CMD_ERASE) || (c == `FSPS_CMD_WRITE) ||
             (c == `FSPS_CMD_LOCKSET) || (c == `FSPS_CMD_RSECT);
   endfunction

   // ****************************************************
   // Decode
   // ****************************************************
   assign addrPhase = ahbIn.hsel & ahbIn.htrans[1] & ahbIn.hready;
   // Control is frozen while an operation runs or the EEPROM is being written
   assign ctrlWrite = s_r.dpValid & s_r.dpWrite & (s_r.dpAddr == `FSPS_CTRL_OFS) &
                      (s_r.fsm == FSPS_IDLE) & ~eepromBusy & ~longOp;
   assign newCmd    = ahbIn.hwdata[4:0];
   // Fetch address plays no part, so any flash location may issue it
   assign spmAccept = spmReq.valid & (s_r.armCnt != 3'h0) & (s_r.fsm == FSPS_IDLE) &
                      s_r.ctrl[`FSPS_ENABLE_BIT];
   assign spmWord   = spmReq.z[WB:1];
   assign spmPage   = spmReq.z[15:WB+1];
   assign longOp    = spmAccept & ((s_r.ctrl == `FSPS_CMD_ERASE) ||
                                   (s_r.ctrl == `FSPS_CMD_WRITE));

   // ****************************************************
   // Next state
   // ****************************************************
   always_comb begin
      s_nxt = s_r;
      s_nxt.flashErase   = 1'b0;
      s_nxt.flashProgram = 1'b0;
      s_nxt.flashWrEn    = 1'b0;
      s_nxt.dpValid      = addrPhase;
      if (addrPhase) begin
         s_nxt.dpWrite = ahbIn.hwrite;
         s_nxt.dpAddr  = ahbIn.haddr;
         s_nxt.hrdata  = 32'h0000_0000;
         if (ahbIn.haddr == `FSPS_CTRL_OFS) begin
            s_nxt.hrdata[4:0] = s_r.ctrl;
         end else if (ahbIn.haddr == `FSPS_STATUS_OFS) begin
            s_nxt.hrdata[`FSPS_STAT_BUSY_BIT] = (s_r.fsm != FSPS_IDLE);
            s_nxt.hrdata[`FSPS_STAT_FILL_BIT] = |s_r.bufValid;
         end
      end
      // Arming window counts down only while idle; long operations hold the bits
      if (s_r.fsm == FSPS_IDLE && s_r.armCnt != 3'h0) begin
         s_nxt.armCnt = s_r.armCnt - 3'h1;
         if (s_r.armCnt == 3'h1) begin
            s_nxt.ctrl = `FSPS_CTRL_RESET;
         end
      end
      if (spmAccept) begin
         s_nxt.armCnt = 3'h0;
         s_nxt.ctrl   = `FSPS_CTRL_RESET;
         case (s_r.ctrl)
            `FSPS_CMD_LOAD: begin
               // A slot already loaded keeps its first word
               if (!s_r.bufValid[spmWord]) begin
                  s_nxt.bufData[spmWord]  = spmReq.data;
                  s_nxt.bufValid[spmWord] = 1'b1;
               end
            end
            `FSPS_CMD_ERASE: begin
               // Buffer untouched so it may be filled on either side of the erase
               s_nxt.ctrl       = s_r.ctrl;
               s_nxt.flashErase = 1'b1;
               s_nxt.page       = spmPage;
               s_nxt.fsm        = FSPS_BUSY;
            end
            `FSPS_CMD_WRITE: begin
               s_nxt.ctrl    = s_r.ctrl;
               s_nxt.page    = spmPage;
               s_nxt.wordIdx = '0;
               s_nxt.fsm     = FSPS_STREAM;
            end
            default: begin
            end
         endcase
      end
      if (ctrlWrite && isValidCmd(newCmd)) begin
         s_nxt.ctrl   = newCmd;
         s_nxt.armCnt = `FSPS_ARM_CYCLES;
         if (newCmd[`FSPS_RSECT_BIT]) begin
            s_nxt.bufValid = '0;
         end
      end
      case (s_r.fsm)
         FSPS_IDLE: begin
         end
         FSPS_STREAM: begin
            // Unloaded slots go out as erased words
            s_nxt.flashWrEn     = 1'b1;
            s_nxt.flashWordAddr = s_r.wordIdx;
            s_nxt.flashWordData = s_r.bufValid[s_r.wordIdx] ? s_r.bufData[s_r.wordIdx] :
                                  `FSPS_ERASED_WORD;
            s_nxt.wordIdx       = s_r.wordIdx + WB'(1);
            if (s_r.wordIdx == WB'(PAGE_WORDS - 1)) begin
               s_nxt.flashProgram = 1'b1;
               s_nxt.fsm          = FSPS_BUSY;
            end
         end
         FSPS_BUSY: begin
            if (flashDone) begin
               s_nxt.fsm = FSPS_FINISH;
            end
         end
         FSPS_FINISH: begin
            if (s_r.ctrl[`FSPS_WRITE_BIT]) begin
               s_nxt.bufValid = '0;
            end
            s_nxt.ctrl = `FSPS_CTRL_RESET;
            s_nxt.fsm  = FSPS_IDLE;
         end
         default: begin
            s_nxt.fsm = FSPS_IDLE;
         end
      endcase
      if (eepromWrite) begin
         s_nxt.bufValid = '0;
      end
   end

   // ****************************************************
   // State register
   // ****************************************************
   // Reset empties the buffer, so no stale word reaches a later page
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ****************************************************
   // Outputs
   // ****************************************************
   assign hreadyout     = 1'b1;
   assign hresp         = 1'b0;
   assign hrdata        = s_r.hrdata;
   // Stall starts in the accepting cycle and all flash is unreadable until done
   assign cpuStall      = (s_r.fsm != FSPS_IDLE) | longOp;
   assign flashErase    = s_r.flashErase;
   assign flashProgram  = s_r.flashProgram;
   assign flashPage     = s_r.page;
   assign flashWrEn     = s_r.flashWrEn;
   assign flashWordAddr = s_r.flashWordAddr;
   assign flashWordData = s_r.flashWordData;

   // ****************************************************
   // Checks
   // ****************************************************
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);

   stall_while_busy_a: assert property ((s_r.fsm != FSPS_IDLE) |-> cpuStall)
      else $error("cpu not stalled during operation");
   erase_launch_a: assert property ((spmAccept && s_r.ctrl == `FSPS_CMD_ERASE) |=>
      (flashErase && s_r.fsm == FSPS_BUSY && flashPage == $past(spmPage)))
      else $error("erase not launched");
   load_store_a: assert property ((spmAccept && s_r.ctrl == `FSPS_CMD_LOAD &&
      !s_r.bufValid[spmWord] && !eepromWrite) |=>
      (s_r.bufData[$past(spmWord)] == $past(spmReq.data)))
      else $error("buffer word not stored");
   write_clears_a: assert property ((s_r.fsm == FSPS_FINISH && s_r.ctrl[`FSPS_WRITE_BIT])
      |=> (s_r.bufValid == '0 && s_r.fsm == FSPS_IDLE && s_r.ctrl == 5'h00))
      else $error("buffer not cleared after write");
   eeprom_discard_a: assert property (eepromWrite |=> (s_r.bufValid == '0))
      else $error("eeprom write kept buffer");
   write_stream_a: assert property ((spmAccept && s_r.ctrl == `FSPS_CMD_WRITE) |=>
      (cpuStall && !flashProgram) [*2] ##[1:300] flashProgram)
      else $error("page write stream broken");
   arm_timeout_a: assert property ((s_r.armCnt == 3'h1 && s_r.fsm == FSPS_IDLE &&
      !spmReq.valid && !ctrlWrite) |=> (s_r.ctrl == 5'h00 && s_r.armCnt == 3'h0))
      else $error("enable did not time out");
   bad_cmd_a: assert property ((ctrlWrite && !isValidCmd(newCmd) && s_r.armCnt == 3'h0 &&
      !spmAccept) |=> (s_r.armCnt == 3'h0 && s_r.ctrl == $past(s_r.ctrl)))
      else $error("undefined command took effect");
   rsect_clear_a: assert property ((ctrlWrite && newCmd == `FSPS_CMD_RSECT) |=>
      (s_r.bufValid == '0))
      else $error("read-section write kept buffer");
   stall_release_a: assert property ($fell(cpuStall) |->
      ($past(s_r.fsm) == FSPS_FINISH))
      else $error("stall released before operation end");
   stall_hold_a: assert property ((s_r.fsm == FSPS_BUSY && !flashDone) |=>
      (s_r.fsm == FSPS_BUSY && cpuStall))
      else $error("stall dropped while flash busy");
   idle_quiet_a: assert property ((s_r.fsm == FSPS_IDLE) |->
      !(flashWrEn || flashProgram || flashErase))
      else $error("flash activity without stall");
   enable_held_a: assert property ((s_r.fsm != FSPS_IDLE) |->
      s_r.ctrl[`FSPS_ENABLE_BIT])
      else $error("enable dropped during operation");
   page_write_a: assert property ((spmAccept && s_r.ctrl == `FSPS_CMD_WRITE) |=>
      (s_r.fsm == FSPS_STREAM && flashPage == $past(spmPage) && s_r.wordIdx == '0))
      else $error("page write not started");
   stream_order_a: assert property ((flashWrEn &&
      flashWordAddr != WB'(PAGE_WORDS - 1)) |=>
      (flashWrEn && flashWordAddr == $past(flashWordAddr) + WB'(1)))
      else $error("page words streamed out of order");
   program_last_a: assert property (flashProgram |->
      (flashWrEn && flashWordAddr == WB'(PAGE_WORDS - 1)))
      else $error("program pulse not with last word");
   erase_single_a: assert property (flashErase |=> !flashErase)
      else $error("erase pulse too long");
   arm_load_a: assert property ((ctrlWrite && isValidCmd(newCmd)) |=>
      (s_r.armCnt == `FSPS_ARM_CYCLES && s_r.ctrl == $past(newCmd)))
      else $error("command not armed");

   // ****************************************************
   // Cover points
   // ****************************************************
   erase_seen_c: cover property (spmAccept && s_r.ctrl == `FSPS_CMD_ERASE);
   erase_done_c: cover property (s_r.fsm == FSPS_FINISH && !s_r.ctrl[`FSPS_WRITE_BIT]);
   write_seen_c: cover property (s_r.fsm == FSPS_FINISH && s_r.ctrl[`FSPS_WRITE_BIT]);
   load_seen_c: cover property (spmAccept && s_r.ctrl == `FSPS_CMD_LOAD);
   timeout_seen_c: cover property (s_r.armCnt == 3'h1 && !spmReq.valid);

endmodule

/* File: fsps_flash_model.sv */
`timescale 1ns/100ps
// ****************************************************
// Flash array stand-in: slow done pulse, page capture
// ****************************************************
module fsps_flash_model #(
   parameter int PAGE_WORDS = 4,
   parameter int DELAY      = 5
) (
   input  wire logic                           mclk,
   input  wire logic                           reset_n,
   input  wire logic                           flashErase,
   input  wire logic                           flashProgram,
   input  wire logic [14-$clog2(PAGE_WORDS):0] flashPage,
   input  wire logic                           flashWrEn,
   input  wire logic [$clog2(PAGE_WORDS)-1:0]  flashWordAddr,
   input  wire logic [15:0]                    flashWordData,
   output logic                                flashDone
);
   logic [15:0]                    words [PAGE_WORDS];
   logic [14-$clog2(PAGE_WORDS):0] erasedPage;
   logic [14-$clog2(PAGE_WORDS):0] progPage;
   int                             cnt;
   // Done comes late on purpose so the stall has to be held
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         cnt <= 0;
         flashDone <= 1'b0;
      end else begin
         flashDone <= (cnt == 1);
         if (cnt > 0) cnt <= cnt - 1;
         if (flashErase) begin
            cnt <= DELAY;
            erasedPage <= flashPage;
         end
         if (flashProgram) begin
            cnt <= DELAY;
            progPage <= flashPage;
         end
         if (flashWrEn) words[flashWordAddr] <= flashWordData;
      end
   end
endmodule

/* File: flash_self_program_sequencer_tb.sv */
`timescale 1ns/100ps
`include "fsps_defines.svh"
module flash_self_program_sequencer_tb;
   import fsps_pkg::*;
   localparam int PW = 4;
   localparam int DL = 5;
   logic                  mclk;
   logic                  reset_n;
   fsps_ahb_in_type       ahbReq;
   fsps_ahb_in_type       ahbIn;
   fsps_spm_req_type      spmReq;
   logic                  eepromWrite;
   logic                  eepromBusy;
   logic                  hreadyout;
   logic                  hresp;
   logic [31:0]           hrdata;
   logic                  cpuStall;
   logic                  flashErase;
   logic                  flashProgram;
   logic [12:0]           flashPage;
   logic                  flashWrEn;
   logic [1:0]            flashWordAddr;
   logic [15:0]           flashWordData;
   logic                  flashDone;
   int                    fail_count = 0;
   int                    check_count = 0;
   always_comb begin
      ahbIn = ahbReq;
      ahbIn.hready = hreadyout;
   end
   fsps_sequencer #(.PAGE_WORDS(PW)) dut (.mclk(mclk), .reset_n(reset_n), .ahbIn(ahbIn),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .spmReq(spmReq),
      .eepromWrite(eepromWrite), .eepromBusy(eepromBusy), .cpuStall(cpuStall),
      .flashErase(flashErase), .flashProgram(flashProgram), .flashPage(flashPage),
      .flashWrEn(flashWrEn), .flashWordAddr(flashWordAddr), .flashWordData(flashWordData),
      .flashDone(flashDone));
   fsps_flash_model #(.PAGE_WORDS(PW), .DELAY(DL)) flashModel (.mclk(mclk), .reset_n(reset_n),
      .flashErase(flashErase), .flashProgram(flashProgram), .flashPage(flashPage),
      .flashWrEn(flashWrEn), .flashWordAddr(flashWordAddr), .flashWordData(flashWordData),
      .flashDone(flashDone));
   // ****************************************************
   // Shared tasks
   // ****************************************************
   task automatic conclude();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic wait_ready();
      int n;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 20);
      if (hreadyout !== 1'b1) begin
         fail_count++;
         conclude();
      end
   endtask
   task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      @(posedge mclk);
      ahbReq.hsel <= 1'b1;
      ahbReq.htrans <= 2'h2;
      ahbReq.haddr <= a;
      ahbReq.hwrite <= wr;
      ahbReq.hsize <= 3'h2;
      wait_ready();
      ahbReq.hsel <= 1'b0;
      ahbReq.htrans <= 2'h0;
      ahbReq.hwdata <= d;
      wait_ready();
      q = hrdata;
      check("hresp", hresp, 0);
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] q;
      ahb(1'b1, a, d, q);
   endtask
   task automatic rd_chk(input string name, input logic [31:0] a, input logic [31:0] e);
      logic [31:0] q;
      ahb(1'b0, a, 32'h0, q);
      check(name, q, e);
   endtask
   task automatic op(input logic [4:0] c, input logic [15:0] z, input logic [15:0] d);
      wr(`FSPS_CTRL_OFS, {27'h0, c});
      @(posedge mclk);
      spmReq <= '{valid: 1'b1, z: z, data: d};
      @(posedge mclk);
      spmReq.valid <= 1'b0;
   endtask
   task automatic wait_idle(output int n);
      n = 0;
      do begin
         @(negedge mclk);
         n++;
      end while (cpuStall === 1'b1 && n < 200);
      if (cpuStall !== 1'b0) begin
         fail_count++;
         conclude();
      end
   endtask
   // ****************************************************
   // Scenarios
   // ****************************************************
   task automatic test_fill_first();
      int n;
      rd_chk("status", `FSPS_STATUS_OFS, 32'h0);
      rd_chk("unmapped", 32'h10, 32'h0);
      op(`FSPS_CMD_LOAD, 16'h002c, 16'h1234);
      op(`FSPS_CMD_LOAD, 16'h0028, 16'h5678);
      rd_chk("fill", `FSPS_STATUS_OFS, 32'h2);
      op(`FSPS_CMD_ERASE, 16'h002b, 16'hdead);
      wait_idle(n);
      check("erase stall", n > DL, 1);
      check("erase page", flashModel.erasedPage, 32'h5);
      rd_chk("fill kept", `FSPS_STATUS_OFS, 32'h2);
      op(`FSPS_CMD_WRITE, 16'h0028, 16'hbeef);
      wait_idle(n);
      check("write stall", n > PW + DL, 1);
      check("write page", flashModel.progPage, 32'h5);
      check("w0", flashModel.words[0], 32'h5678);
      check("w1", flashModel.words[1], 32'hffff);
      check("w2", flashModel.words[2], 32'h1234);
      check("w3", flashModel.words[3], 32'hffff);
      rd_chk("cleared", `FSPS_STATUS_OFS, 32'h0);
      rd_chk("ctrl", `FSPS_CTRL_OFS, 32'h0);
      $display("done fill_first");
   endtask
   task automatic test_fill_after();
      int n;
      op(`FSPS_CMD_ERASE, 16'h0048, 16'h0);
      wait_idle(n);
      check("erase page", flashModel.erasedPage, 32'h9);
      for (int i = 0; i < PW; i++) begin
         op(`FSPS_CMD_LOAD, 16'h0049 | 16'(i << 1), 16'ha000 + 16'(i));
      end
      op(`FSPS_CMD_WRITE, 16'h0048, 16'h0);
      wait_idle(n);
      check("write page", flashModel.progPage, 32'h9);
      for (int i = 0; i < PW; i++) begin
         check("word", flashModel.words[i], 32'ha000 + i);
      end
      $display("done fill_after");
   endtask
   task automatic test_clears();
      op(`FSPS_CMD_LOAD, 16'h0002, 16'h1111);
      rd_chk("loaded a", `FSPS_STATUS_OFS, 32'h2);
      @(posedge mclk);
      eepromWrite <= 1'b1;
      @(posedge mclk);
      eepromWrite <= 1'b0;
      rd_chk("eeprom", `FSPS_STATUS_OFS, 32'h0);
      op(`FSPS_CMD_LOAD, 16'h0004, 16'h2222);
      rd_chk("loaded b", `FSPS_STATUS_OFS, 32'h2);
      wr(`FSPS_CTRL_OFS, {27'h0, `FSPS_CMD_RSECT});
      rd_chk("rsect", `FSPS_STATUS_OFS, 32'h0);
      op(`FSPS_CMD_LOAD, 16'h0006, 16'h3333);
      rd_chk("loaded c", `FSPS_STATUS_OFS, 32'h2);
      @(posedge mclk);
      reset_n <= 1'b0;
      @(posedge mclk);
      reset_n <= 1'b1;
      rd_chk("reset", `FSPS_STATUS_OFS, 32'h0);
      $display("done clears");
   endtask
   task automatic test_refused();
      logic [4:0] bad [3] = '{5'h07, 5'h13, 5'h0f};
      wr(`FSPS_CTRL_OFS, {27'h0, `FSPS_CMD_LOAD});
      rd_chk("armed", `FSPS_CTRL_OFS, 32'h1);
      repeat (6) @(posedge mclk);
      rd_chk("expired", `FSPS_CTRL_OFS, 32'h0);
      op(5'h00, 16'h0002, 16'h4444);
      rd_chk("late spm", `FSPS_STATUS_OFS, 32'h0);
      for (int i = 0; i < 3; i++) begin
         wr(`FSPS_CTRL_OFS, {27'h0, bad[i]});
         rd_chk("bad ctrl", `FSPS_CTRL_OFS, 32'h0);
         op(bad[i], 16'h0002, 16'h5555);
         rd_chk("bad code", `FSPS_STATUS_OFS, 32'h0);
      end
      op(`FSPS_CMD_LOCKSET, 16'h0002, 16'h6666);
      rd_chk("lockset", `FSPS_STATUS_OFS, 32'h0);
      @(posedge mclk);
      eepromBusy <= 1'b1;
      op(`FSPS_CMD_LOAD, 16'h0002, 16'h7777);
      rd_chk("busy", `FSPS_STATUS_OFS, 32'h0);
      eepromBusy <= 1'b0;
      $display("done refused");
   endtask
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   initial begin
      reset_n = 1'b0;
      ahbReq = '0;
      spmReq = '0;
      eepromWrite = 1'b0;
      eepromBusy = 1'b0;
      repeat (4) @(posedge mclk);
      reset_n <= 1'b1;
      test_fill_first();
      test_fill_after();
      test_clears();
      test_refused();
      conclude();
   end
endmodule
